// [rmsc_pkg.sv]
package rmsc_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'h0,
        MODE_WOR    = 2'h1,
        MODE_CONFIG = 2'h2,
        MODE_SLEEP  = 2'h3
    } rmsc_mode_type;

    // Gray codes along check, run, settle.
    typedef enum logic [1:0] {
        ST_CHECK  = 2'h0,
        ST_RUN    = 2'h1,
        ST_SETTLE = 2'h3
    } rmsc_state_type;

    localparam int CLK_FREQ_MHZ      = 200;
    localparam int SETTLE_TIME_US    = 2000;
    localparam int SETTLE_CYCLES     = SETTLE_TIME_US * CLK_FREQ_MHZ;
    localparam int SELFCHECK_TIME_US = 50;
    localparam int SELFCHECK_CYCLES  = SELFCHECK_TIME_US * CLK_FREQ_MHZ;
    localparam int TIMER_W           = 20;

    localparam int BUFFER_BYTES      = 1000;
    localparam int SUBPACKET_BYTES   = 240;

    localparam logic [15:0] ADDR_ALL_ONES  = 16'hffff;
    localparam logic [15:0] ADDR_ALL_ZEROS = 16'h0000;
    localparam logic [15:0] RESET_OWN_ADDR = 16'h0001;
    localparam rmsc_mode_type RESET_MODE   = MODE_NORMAL;

    // Both special addresses mean "everyone on the channel".
    function automatic logic rmsc_is_bcast(input logic [15:0] addr);
        return (addr == ADDR_ALL_ONES) || (addr == ADDR_ALL_ZEROS);
    endfunction

endpackage

// [rmsc_timer.sv]
module rmsc_timer
    import rmsc_pkg::*;
#(
    parameter int W = TIMER_W
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_reset_n,
    input  wire logic         i_start,
    input  wire logic [W-1:0] i_count,
    output logic              o_busy
);

    logic [W-1:0] cnt_r;

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_r <= '0;
        end else if (i_start) begin
            cnt_r <= i_count;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - W'(1);
        end
    end

    assign o_busy = (cnt_r != '0);

endmodule

// [rmsc_byte_fifo.sv]
module rmsc_byte_fifo
    import rmsc_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = BUFFER_BYTES
) (
    input  wire logic                       i_clk_sys,
    input  wire logic                       i_reset_n,
    input  wire logic                       i_push,
    input  wire logic [WIDTH-1:0]           i_data,
    input  wire logic                       i_pop,
    output logic      [WIDTH-1:0]           o_data,
    output logic                            o_empty,
    output logic      [$clog2(DEPTH+1)-1:0] o_level
);

    localparam int PW = $clog2(DEPTH);
    localparam int LW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [LW-1:0]    level_r;
    logic             do_push;
    logic             do_pop;

    // A push into a full buffer is dropped rather than corrupting old bytes.
    assign do_push = i_push && (level_r != LW'(DEPTH));
    assign do_pop  = i_pop && (level_r != '0);

    always_ff @(posedge i_clk_sys) begin
        if (do_push) begin
            mem[wr_ptr_r] <= i_data;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + PW'(1);
            end
            if (do_pop) begin
                rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + PW'(1);
            end
            level_r <= level_r + LW'(do_push) - LW'(do_pop);
        end
    end

    assign o_data  = mem[rd_ptr_r];
    assign o_empty = (level_r == '0);
    assign o_level = level_r;

endmodule

// [rmsc_top.sv]
module rmsc_top
    import rmsc_pkg::*;
#(
    parameter int SETTLE_CYCLES_P    = SETTLE_CYCLES,
    parameter int SELFCHECK_CYCLES_P = SELFCHECK_CYCLES,
    parameter int BUF_DEPTH          = BUFFER_BYTES,
    parameter int SUBPKT_LEN         = SUBPACKET_BYTES
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_reset_n,
    input  wire logic        i_mode_select_low,
    input  wire logic        i_mode_select_high,
    input  wire logic        i_cfg_wor_tx,
    input  wire logic [15:0] i_cfg_own_addr,
    input  wire logic        i_host_valid,
    input  wire logic [7:0]  i_host_data,
    output logic             o_host_ready,
    input  wire logic        i_radio_ready,
    output logic             o_radio_valid,
    output logic [7:0]       o_radio_data,
    output logic             o_radio_sop,
    output logic             o_radio_preamble,
    input  wire logic        i_air_valid,
    input  wire logic [7:0]  i_air_data,
    input  wire logic [15:0] i_air_addr,
    output logic             o_air_ready,
    input  wire logic        i_uart_ready,
    output logic             o_uart_valid,
    output logic [7:0]       o_uart_data,
    output logic             o_busy_n,
    output logic [1:0]       o_mode,
    output logic             o_radio_tx_en,
    output logic             o_radio_rx_en,
    output logic             o_broadcast,
    output logic             o_monitor,
    output logic             o_config_access
);

    localparam int LW = $clog2(BUF_DEPTH + 1);
    localparam int SW = $clog2(SUBPKT_LEN);

    rmsc_state_type     state_r;
    rmsc_mode_type      mode_r;
    rmsc_mode_type      req_mode;
    logic               seen_busy_r;
    logic               cfg_wor_tx_r;
    logic [15:0]        own_addr_r;

    logic               tmr_start_r;
    logic [TIMER_W-1:0] tmr_count_r;
    logic               tmr_busy;

    logic               fifo_push;
    logic               fifo_pop;
    logic [7:0]         fifo_data;
    logic               fifo_empty;
    logic [LW-1:0]      fifo_level;
    logic [SW-1:0]      sub_cnt_r;

    logic               air_take;
    logic               air_keep;
    logic               uart_valid_nxt;

    logic               busy;
    logic               tx_ok;
    logic               rx_ok;
    logic               mode_differs;
    logic               check_done;

    assign req_mode     = rmsc_mode_type'({i_mode_select_high, i_mode_select_low});
    assign mode_differs = (req_mode != mode_r);
    assign check_done   = !tmr_busy && !tmr_start_r;

    // Pending serial output keeps it low.
    // Last radio byte may still be in flight.
    // The radio stage register is left out on purpose, so the indicator
    // may rise while the final byte is still with the radio chip.
    assign busy = (state_r == ST_CHECK) || !fifo_empty || o_uart_valid;

    assign tx_ok = (state_r == ST_RUN) && ((mode_r == MODE_NORMAL) || (mode_r == MODE_WOR));
    assign rx_ok = tx_ok;

    rmsc_timer #(
        .W        (TIMER_W)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_start  (tmr_start_r),
        .i_count  (tmr_count_r),
        .o_busy   (tmr_busy)
    );

    // Self-check starts straight out of reset.
    // Only reset and sleep exit start a self-check.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_r     <= ST_CHECK;
            mode_r      <= RESET_MODE;
            tmr_start_r <= 1'b1;
            tmr_count_r <= TIMER_W'(SELFCHECK_CYCLES_P);
        end else begin
            tmr_start_r <= 1'b0;
            unique case (state_r)
                ST_CHECK: begin
                    // Run the pin-selected mode once the check ends.
                    if (check_done) begin
                        mode_r  <= req_mode;
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Pins evaluated only while not busy.
                    // Buffered and serial-output data finish before the switch.
                    if (mode_differs && !busy) begin
                        mode_r <= req_mode;
                        if (mode_r == MODE_SLEEP) begin
                            state_r     <= ST_CHECK;
                            tmr_start_r <= 1'b1;
                            tmr_count_r <= TIMER_W'(SELFCHECK_CYCLES_P);
                        end else if (seen_busy_r || !o_busy_n) begin
                            // Hold off the new mode for 2 ms.
                            state_r     <= ST_SETTLE;
                            tmr_start_r <= 1'b1;
                            tmr_count_r <= TIMER_W'(SETTLE_CYCLES_P);
                        end
                        // Otherwise the new mode applies at once.
                    end
                end
                ST_SETTLE: begin
                    if (check_done) begin
                        state_r <= ST_RUN;
                    end
                end
                default: begin
                    state_r <= ST_CHECK;
                end
            endcase
        end
    end

    // Remembers that a requested switch met a busy period.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seen_busy_r <= 1'b0;
        end else if (state_r != ST_RUN || !mode_differs) begin
            seen_busy_r <= 1'b0;
        end else if (busy) begin
            seen_busy_r <= 1'b1;
        end
    end

    // Stored parameters are taken as the check ends, never under reset.
    // Wake-on-radio role comes from the stored parameters.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_wor_tx_r <= 1'b0;
            own_addr_r   <= RESET_OWN_ADDR;
        end else if (state_r == ST_CHECK && check_done) begin
            cfg_wor_tx_r <= i_cfg_wor_tx;
            own_addr_r   <= i_cfg_own_addr;
        end
    end

    rmsc_byte_fifo #(
        .WIDTH    (8),
        .DEPTH    (BUF_DEPTH)
    ) u_tx_buf (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_push   (fifo_push),
        .i_data   (i_host_data),
        .i_pop    (fifo_pop),
        .o_data   (fifo_data),
        .o_empty  (fifo_empty),
        .o_level  (fifo_level)
    );

    // Host bytes arrive deframed.
    // Serial framing sits in the pad logic, so this block sees whole bytes only.
    assign fifo_push = i_host_valid && o_host_ready;
    assign fifo_pop  = tx_ok && !fifo_empty && (!o_radio_valid || i_radio_ready);

    // Ready lags one cycle, so the threshold leaves one spare slot.
    // While transmit is enabled, a burst below the buffer size is never refused.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_host_ready <= 1'b0;
        end else begin
            o_host_ready <= tx_ok && (fifo_level < LW'(BUF_DEPTH - 1));
        end
    end

    // Bytes go to the radio in sub-packets.
    // In wake-on-radio mode with the stored transmit role set, a wake preamble marks each sub-packet start.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_radio_valid    <= 1'b0;
            o_radio_data     <= 8'h00;
            o_radio_sop      <= 1'b0;
            o_radio_preamble <= 1'b0;
        end else if (fifo_pop) begin
            o_radio_valid    <= 1'b1;
            o_radio_data     <= fifo_data;
            o_radio_sop      <= (sub_cnt_r == '0);
            o_radio_preamble <= (sub_cnt_r == '0) && (mode_r == MODE_WOR) && cfg_wor_tx_r;
        end else if (i_radio_ready) begin
            o_radio_valid    <= 1'b0;
            o_radio_sop      <= 1'b0;
            o_radio_preamble <= 1'b0;
        end
    end

    // Sub-packet position counter.
    // A drained buffer closes the current sub-packet early.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sub_cnt_r <= '0;
        end else if (fifo_pop) begin
            sub_cnt_r <= (sub_cnt_r == SW'(SUBPKT_LEN - 1)) ? '0 : sub_cnt_r + SW'(1);
        end else if (fifo_empty && !o_radio_valid) begin
            sub_cnt_r <= '0;
        end
    end

    // Monitor address takes every packet on the channel.
    assign air_take = i_air_valid && o_air_ready;
    assign air_keep = air_take && (rmsc_is_bcast(own_addr_r) || (i_air_addr == own_addr_r));

    always_comb begin
        uart_valid_nxt = o_uart_valid;
        if (o_uart_valid && i_uart_ready) begin
            uart_valid_nxt = 1'b0;
        end
        if (air_keep) begin
            uart_valid_nxt = 1'b1;
        end
    end

    // Kept air bytes (own address or monitor) pass to the serial side.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_uart_valid <= 1'b0;
            o_uart_data  <= 8'h00;
        end else begin
            o_uart_valid <= uart_valid_nxt;
            if (air_keep) begin
                o_uart_data <= i_air_data;
            end
        end
    end

    // Ready is registered, so it drops in the cycle after an addressed byte is kept
    // and a second byte can never overwrite one still waiting for output.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_air_ready <= 1'b0;
        end else begin
            o_air_ready <= rx_ok && !uart_valid_nxt;
        end
    end

    // Indicator high only when self-check, buffer and serial output are all idle.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_busy_n <= 1'b0;
        end else begin
            o_busy_n <= !busy;
        end
    end

    // Reported mode follows the applied mode, not the pins.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mode        <= 2'h0;
            o_radio_tx_en <= 1'b0;
            o_radio_rx_en <= 1'b0;
        end else begin
            o_mode        <= mode_r;
            o_radio_tx_en <= tx_ok;
            o_radio_rx_en <= rx_ok;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_broadcast <= 1'b0;
            o_monitor   <= 1'b0;
        end else begin
            o_broadcast <= tx_ok && rmsc_is_bcast(own_addr_r);
            o_monitor   <= rx_ok && rmsc_is_bcast(own_addr_r);
        end
    end

    // Register access only in configuration mode.
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_config_access <= 1'b0;
        end else begin
            o_config_access <= (state_r == ST_RUN) && (mode_r == MODE_CONFIG);
        end
    end

endmodule

// [rmsc_checker.sv]
module rmsc_checker
    import rmsc_pkg::*;
(
    input wire logic       i_clk_sys,
    input wire logic       i_reset_n,
    input wire logic       i_host_valid,
    input wire logic       o_host_ready,
    input wire logic       i_radio_ready,
    input wire logic       o_radio_valid,
    input wire logic [7:0] o_radio_data,
    input wire logic       o_radio_sop,
    input wire logic       o_radio_preamble,
    input wire logic       o_uart_valid,
    input wire logic       o_busy_n,
    input wire logic [1:0] o_mode,
    input wire logic       o_radio_tx_en,
    input wire logic       o_radio_rx_en,
    input wire logic       o_config_access
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence s_host_take;
        i_host_valid && o_host_ready;
    endsequence
    sequence s_busy_later;
        ##2 !o_busy_n;
    endsequence
    reset_busy_a: assert property ($rose(i_reset_n) |-> !o_busy_n [*8])
        else $error("busy indicator high during self-check");
    host_busy_a: assert property (s_host_take |-> s_busy_later)
        else $error("busy indicator not low after host byte");
    mode_hold_a: assert property (!o_busy_n && !$past(o_busy_n) |-> $stable(o_mode))
        else $error("mode changed while busy");
    uart_busy_a: assert property (o_uart_valid && $past(o_uart_valid) |-> !o_busy_n)
        else $error("busy indicator high with serial output pending");
    radio_hold_a: assert property (o_radio_valid && !i_radio_ready |=>
        o_radio_valid && $stable(o_radio_data) && $stable(o_radio_sop))
        else $error("radio byte not held");
    wake_pre_a: assert property (o_radio_preamble |-> o_radio_sop && o_mode == MODE_WOR)
        else $error("preamble outside wake-on-radio packet start");
    cfg_off_a: assert property (o_mode == MODE_CONFIG && $past(o_mode) == MODE_CONFIG
        |-> !o_radio_tx_en && !o_radio_rx_en)
        else $error("radio on in configuration mode");
    sleep_off_a: assert property (o_mode == MODE_SLEEP && $past(o_mode) == MODE_SLEEP
        |-> !o_radio_tx_en && !o_radio_rx_en)
        else $error("radio on in deep sleep");
    cfg_access_a: assert property (o_config_access |-> o_mode == MODE_CONFIG)
        else $error("register access outside configuration mode");
endmodule

// [rmsc_host_model.sv]
module rmsc_host_model (
    input  wire logic       i_clk_sys,
    input  wire logic       i_reset_n,
    input  wire logic       i_slow,
    input  wire logic       i_radio_valid,
    input  wire logic [7:0] i_radio_data,
    input  wire logic       i_radio_sop,
    input  wire logic       i_radio_pre,
    input  wire logic       i_uart_valid,
    input  wire logic [7:0] i_uart_data,
    output logic            o_radio_ready,
    output logic            o_uart_ready,
    output logic [15:0]     o_rad_cnt,
    output logic [15:0]     o_sop_cnt,
    output logic [15:0]     o_pre_cnt,
    output logic [15:0]     o_uart_cnt,
    output logic [7:0]      o_rad_last,
    output logic [7:0]      o_uart_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic phase = 1'b0;
    // A slow far side stalls every other cycle, so holding logic is exercised.
    always @(negedge i_clk_sys) begin
        phase <= !phase;
        o_radio_ready <= !i_slow || phase;
        o_uart_ready <= !i_slow || !phase;
    end
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            {o_rad_cnt, o_sop_cnt, o_pre_cnt, o_uart_cnt} <= '0;
            {o_rad_last, o_uart_last} <= '0;
        end else begin
            if (i_radio_valid && o_radio_ready) begin
                o_rad_cnt <= o_rad_cnt + 16'h1;
                o_sop_cnt <= o_sop_cnt + 16'(i_radio_sop);
                o_pre_cnt <= o_pre_cnt + 16'(i_radio_pre);
                o_rad_last <= i_radio_data;
            end
            if (i_uart_valid && o_uart_ready) begin
                o_uart_cnt <= o_uart_cnt + 16'h1;
                o_uart_last <= i_uart_data;
            end
        end
    end
endmodule

// [tb.sv]
module tb;
    import rmsc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SUB = 4;
    localparam int SET = 20;
    logic i_clk_sys = 1'b0, i_reset_n = 1'b0, i_slow = 1'b1;
    logic i_mode_select_low = 1'b0, i_mode_select_high = 1'b0, i_cfg_wor_tx = 1'b1;
    logic i_host_valid = 1'b0, i_air_valid = 1'b0;
    logic [7:0] i_host_data = 8'h00, i_air_data = 8'h00;
    logic [15:0] i_cfg_own_addr = 16'h0001, i_air_addr = 16'h0000;
    logic i_radio_ready, i_uart_ready, o_host_ready, o_radio_valid, o_radio_sop;
    logic o_radio_preamble, o_air_ready, o_uart_valid, o_busy_n, o_radio_tx_en;
    logic o_radio_rx_en, o_broadcast, o_monitor, o_config_access;
    logic [7:0] o_radio_data, o_uart_data, rad_last, uart_last;
    logic [1:0] o_mode;
    logic [15:0] rad_cnt, sop_cnt, pre_cnt, uart_cnt, r0, s0, p0, u0;
    int bad_count = 0;
    int n_tests = 0;
    always #2.5 i_clk_sys = !i_clk_sys;
    rmsc_top #(.SETTLE_CYCLES_P(SET), .SELFCHECK_CYCLES_P(10), .BUF_DEPTH(16),
        .SUBPKT_LEN(SUB)) dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_mode_select_low(i_mode_select_low), .i_mode_select_high(i_mode_select_high),
        .i_cfg_wor_tx(i_cfg_wor_tx), .i_cfg_own_addr(i_cfg_own_addr),
        .i_host_valid(i_host_valid), .i_host_data(i_host_data), .o_host_ready(o_host_ready),
        .i_radio_ready(i_radio_ready), .o_radio_valid(o_radio_valid),
        .o_radio_data(o_radio_data), .o_radio_sop(o_radio_sop),
        .o_radio_preamble(o_radio_preamble), .i_air_valid(i_air_valid),
        .i_air_data(i_air_data), .i_air_addr(i_air_addr), .o_air_ready(o_air_ready),
        .i_uart_ready(i_uart_ready), .o_uart_valid(o_uart_valid), .o_uart_data(o_uart_data),
        .o_busy_n(o_busy_n), .o_mode(o_mode), .o_radio_tx_en(o_radio_tx_en),
        .o_radio_rx_en(o_radio_rx_en), .o_broadcast(o_broadcast), .o_monitor(o_monitor),
        .o_config_access(o_config_access));
    rmsc_host_model far_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_slow(i_slow),
        .i_radio_valid(o_radio_valid), .i_radio_data(o_radio_data), .i_radio_sop(o_radio_sop),
        .i_radio_pre(o_radio_preamble), .i_uart_valid(o_uart_valid), .i_uart_data(o_uart_data),
        .o_radio_ready(i_radio_ready), .o_uart_ready(i_uart_ready), .o_rad_cnt(rad_cnt),
        .o_sop_cnt(sop_cnt), .o_pre_cnt(pre_cnt), .o_uart_cnt(uart_cnt),
        .o_rad_last(rad_last), .o_uart_last(uart_last));
    task automatic stop_test;
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic lim(input int k);
        if (k >= 400) begin
            chk("wait bound", 16'h0, 16'h1);
            stop_test();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask
    task automatic wait_busy(input logic lvl);
        int k;
        k = 0;
        while (o_busy_n !== lvl && k < 400) begin
            tick(1);
            k++;
        end
        lim(k);
    endtask
    task automatic pins(input logic [1:0] m);
        {i_mode_select_high, i_mode_select_low} = m;
    endtask
    task automatic snap;
        {r0, s0, p0, u0} = {rad_cnt, sop_cnt, pre_cnt, uart_cnt};
    endtask
    // Each host byte waits only for ready, not for idle; valid is held across back-to-back bytes.
    task automatic send_host(input int n, input logic [7:0] base);
        int k;
        for (int i = 0; i < n; i++) begin
            i_host_valid = 1'b1;
            i_host_data = base + 8'(i);
            k = 0;
            while (o_host_ready !== 1'b1 && k < 400) begin
                tick(1);
                k++;
            end
            lim(k);
            tick(1);
        end
        i_host_valid = 1'b0;
    endtask
    task automatic send_air(input logic [7:0] d, input logic [15:0] a);
        int k;
        {i_air_valid, i_air_data, i_air_addr} = {1'b1, d, a};
        k = 0;
        while (o_air_ready !== 1'b1 && k < 400) begin
            tick(1);
            k++;
        end
        lim(k);
        tick(1);
        i_air_valid = 1'b0;
    endtask
    task automatic t_reset;
        tick(3);
        chk("busy in self-check", 16'h0, 16'(o_busy_n));
        // Use only after the first rising edge of the indicator.
        wait_busy(1'b1);
        chk("mode after check", 16'h0, 16'(o_mode));
        $display("t_reset done");
    endtask
    task automatic t_modes;
        logic [1:0] seq_m [3] = '{2'h1, 2'h2, 2'h0};
        foreach (seq_m[i]) begin
            pins(seq_m[i]);
            tick(3);
            chk("idle mode", 16'(seq_m[i]), 16'(o_mode));
            chk("idle busy", 16'h1, 16'(o_busy_n));
            chk("tx enable", 16'(seq_m[i] != 2'h2), 16'(o_radio_tx_en));
            chk("cfg access", 16'(seq_m[i] == 2'h2), 16'(o_config_access));
        end
        $display("t_modes done");
    endtask
    task automatic t_tx(input logic [1:0] m, input int n, input logic [15:0] pre);
        pins(m);
        tick(SET + 10);
        snap();
        send_host(n, 8'h10);
        chk("busy after bytes", 16'h0, 16'(o_busy_n));
        wait_busy(1'b1);
        tick(10);
        chk("radio bytes", 16'(n), rad_cnt - r0);
        chk("sub-packets", 16'((n + SUB - 1) / SUB), sop_cnt - s0);
        chk("last byte", 16'(8'h10 + 8'(n - 1)), 16'(rad_last));
        chk("preambles", pre, pre_cnt - p0);
        $display("t_tx done");
    endtask
    task automatic t_rx;
        snap();
        send_air(8'h5a, 16'h0001);
        tick(1);
        chk("busy serial out", 16'h0, 16'(o_busy_n));
        wait_busy(1'b1);
        chk("serial byte", 16'h5a, 16'(uart_last));
        send_air(8'h33, 16'h0002);
        tick(20);
        chk("dropped byte", u0 + 16'h1, uart_cnt);
        chk("no monitor", 16'h0, 16'(o_monitor));
        chk("no broadcast", 16'h0, 16'(o_broadcast));
        $display("t_rx done");
    endtask
    task automatic t_sleep;
        pins(2'h3);
        tick(SET + 10);
        chk("sleep mode", 16'h3, 16'(o_mode));
        chk("sleep idle", 16'h1, 16'(o_busy_n));
        chk("sleep rx", 16'h0, 16'(o_radio_rx_en));
        i_cfg_own_addr = 16'hffff;
        pins(2'h0);
        tick(3);
        chk("reload busy", 16'h0, 16'(o_busy_n));
        wait_busy(1'b1);
        tick(3);
        chk("woken mode", 16'h0, 16'(o_mode));
        chk("broadcast on", 16'h1, 16'(o_broadcast));
        chk("monitor on", 16'h1, 16'(o_monitor));
        send_air(8'h66, 16'h0002);
        tick(20);
        chk("monitored byte", 16'h66, 16'(uart_last));
        $display("t_sleep done");
    endtask
    task automatic t_late_switch;
        send_host(8, 8'h40);
        // Pins move while busy on purpose; the switch must wait.
        pins(2'h1);
        tick(2);
        chk("held mode", 16'h0, 16'(o_mode));
        wait_busy(1'b1);
        tick(3);
        chk("late mode", 16'h1, 16'(o_mode));
        chk("settle tx off", 16'h0, 16'(o_radio_tx_en));
        tick(SET + 5);
        chk("settled tx on", 16'h1, 16'(o_radio_tx_en));
        $display("t_late_switch done");
    endtask
    initial begin
        tick(5);
        i_reset_n = 1'b1;
        t_reset();
        t_modes();
        t_tx(2'h0, 6, 16'h0);
        t_tx(2'h1, 5, 16'h2);
        pins(2'h0);
        tick(SET + 10);
        t_rx();
        t_sleep();
        t_late_switch();
        stop_test();
    end
endmodule
bind rmsc_top rmsc_checker chk_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_host_valid(i_host_valid), .o_host_ready(o_host_ready), .i_radio_ready(i_radio_ready),
    .o_radio_valid(o_radio_valid), .o_radio_data(o_radio_data), .o_radio_sop(o_radio_sop),
    .o_radio_preamble(o_radio_preamble), .o_uart_valid(o_uart_valid), .o_busy_n(o_busy_n),
    .o_mode(o_mode), .o_radio_tx_en(o_radio_tx_en), .o_radio_rx_en(o_radio_rx_en),
    .o_config_access(o_config_access));
